// file: pcc_pkg.sv
/*
  Shared constants and types for the card-slot host port: the strap
  field layout, the local register window and the state encodings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package pcc_pkg;
  localparam int          ADDR_W           = 24;
  localparam int          LOW_W            = 13;
  localparam int          UP_W             = 11;
  localparam int          DATA_W           = 16;
  localparam int          STRAP_W          = 16;
  localparam int          STRAP_BUS_LSB    = 1;
  localparam int          STRAP_ENDIAN     = 4;
  localparam int          STRAP_HOLD_POL   = 5;
  localparam int          STRAP_ALT        = 11;
  localparam int          STRAP_HALVE      = 12;
  localparam int          STRAP_HOLD_DRV   = 15;
  localparam logic [2:0]  BUS_TYPE_ALT     = 3'h7;
  localparam logic [1:0]  STRAP_SETTLE     = 2'h2;
  localparam int          MEM_SPACE_BIT    = 23;
  localparam logic [ADDR_W-1:0] REG_ID_ADDR   = 24'h000000;
  localparam logic [ADDR_W-1:0] REG_MISC_ADDR = 24'h000001;
  localparam int          MISC_LOCK_BIT    = 7;
  localparam logic [7:0]  MISC_RESET       = 8'h80;
  localparam logic [7:0]  ID_DEFAULT       = 8'h5a;
  localparam int          HOST_PHASE_CYC   = 4;

  typedef enum logic [1:0] {
    PCC_DEV_IDLE = 2'b00,
    PCC_DEV_BUSY = 2'b01,
    PCC_DEV_DONE = 2'b11
  } pcc_dev_st_t;

  typedef enum logic [2:0] {
    PCC_H_IDLE   = 3'b000,
    PCC_H_ALE    = 3'b001,
    PCC_H_LATCH  = 3'b011,
    PCC_H_SETUP  = 3'b010,
    PCC_H_STROBE = 3'b110,
    PCC_H_END    = 3'b111
  } pcc_host_st_t;
endpackage
`default_nettype wire

// file: pcc_if.sv
/*
  Pin level carrier between the processor end and the controller end.
  Works out the shared data bus and the hold wire from the enables;
  undriven wires read high like the board pull-ups.
*/
`timescale 1ns/100ps
`default_nettype none
interface pcc_if;
  logic        upper_addr_latch_in;
  logic        card_space_select_n;
  logic        io_read_strobe_n;
  logic        io_write_strobe_n;
  logic        general_read_strobe_n;
  logic        low_write_strobe_n;
  logic        high_byte_select_n;
  logic        low_byte_select_n;
  logic        mem_reg_select_n;
  logic        chip_select_n;
  logic        bus_start_n;
  logic [3:0]  unused_addr_inputs;
  logic [12:0] muxed_addr_in;
  logic [15:0] dev_data_out;
  logic        dev_data_oe;
  logic [15:0] host_data_out;
  logic        host_data_oe;
  logic [15:0] host_data_bus;
  logic        hold_out;
  logic        hold_oe;
  logic        hold_level;

  // device upper lane is processor bits 23:16, lower lane bits 31:24
  assign host_data_bus = dev_data_oe ? dev_data_out :
                         (host_data_oe ? host_data_out : 16'hffff);
  assign hold_level    = hold_oe ? hold_out : 1'b1;

  modport dev (
    input  upper_addr_latch_in, card_space_select_n, io_read_strobe_n,
    input  io_write_strobe_n, general_read_strobe_n, low_write_strobe_n,
    input  high_byte_select_n, low_byte_select_n, mem_reg_select_n,
    input  chip_select_n, bus_start_n, unused_addr_inputs, muxed_addr_in,
    input  host_data_bus,
    output dev_data_out, dev_data_oe, hold_out, hold_oe
  );
  modport host (
    output upper_addr_latch_in, card_space_select_n, io_read_strobe_n,
    output io_write_strobe_n, general_read_strobe_n, low_write_strobe_n,
    output high_byte_select_n, low_byte_select_n, mem_reg_select_n,
    output chip_select_n, bus_start_n, unused_addr_inputs, muxed_addr_in,
    output host_data_out, host_data_oe,
    input  host_data_bus, hold_level
  );
endinterface // pcc_if
`default_nettype wire

// file: pcc_dev.sv
/*
  Controller end of the card-slot host port: strap capture, pin
  synchronisers, upper address latch, access sequencer with hold
  insertion, the local id and lock registers, and a request port
  towards the internal arbiter.
  Assumes clk_i is the host bus clock and that the arbiter holds
  req_ack_i until it sees req_o fall.
*/
`timescale 1ns/100ps
`default_nettype none
module pcc_dev
  import pcc_pkg::*;
#(
  parameter logic [7:0] ID_VALUE = ID_DEFAULT // arbitrary value
)(
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  pcc_if.dev                     bus,
  input  wire logic [STRAP_W-1:0] config_straps_i,
  output logic                   req_o,
  output logic                   req_we_o,
  output logic [ADDR_W-1:0]      req_addr_o,
  output logic [1:0]             req_be_o,
  output logic [DATA_W-1:0]      req_wdata_o,
  input  wire logic              req_ack_i,
  input  wire logic [DATA_W-1:0] req_rdata_i,
  output logic                   cfg_valid_o,
  output logic                   mode_active_o,
  output logic                   big_endian_o,
  output logic                   regmem_lock_o
);

  ////////////////////////////////////////////////////////////////////
  // state

  localparam int SYNC_W = STRAP_W + 8 + LOW_W + DATA_W;

  typedef struct packed {
    logic [SYNC_W-1:0]  s1;
    logic [SYNC_W-1:0]  s2;
    logic [STRAP_W-1:0] straps;
    logic               cfg_done;
    logic [1:0]         settle;
    logic               ale_prev;
    logic [UP_W-1:0]    upper;
    logic               phase;
    pcc_dev_st_t        st;
    logic [ADDR_W-1:0]  addr;
    logic               we;
    logic [1:0]         be;
    logic [DATA_W-1:0]  wdata;
    logic [DATA_W-1:0]  rdata;
    logic [7:0]         misc;
  } pcc_dev_state_t;

  localparam pcc_dev_state_t RESET_STATE = '{
    s1: '0, s2: '0, straps: '0, cfg_done: 1'b0, settle: 2'h0,
    ale_prev: 1'b0, upper: '0, phase: 1'b0, st: PCC_DEV_IDLE,
    addr: '0, we: 1'b0, be: 2'h0, wdata: '0, rdata: '0,
    misc: MISC_RESET
  };

  pcc_dev_state_t r;
  pcc_dev_state_t next_r;

  // byte order of the host relative to the internal little endian view
  function automatic logic [DATA_W-1:0] pcc_swap(input logic [DATA_W-1:0] d,
                                                 input logic big);
    pcc_swap = big ? {d[7:0], d[15:8]} : d;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // synchronised pins

  logic [STRAP_W-1:0] s_straps;
  logic               s_ale;
  logic               s_sel_n;
  logic               s_iord_n;
  logic               s_iowr_n;
  logic               s_rd_n;
  logic               s_we0_n;
  logic               s_csh_n;
  logic               s_csl_n;
  logic [LOW_W-1:0]   s_addr;
  logic [DATA_W-1:0]  s_data;

  assign {s_straps, s_ale, s_sel_n, s_iord_n, s_iowr_n, s_rd_n, s_we0_n,
          s_csh_n, s_csl_n, s_addr, s_data} = r.s2;

  ////////////////////////////////////////////////////////////////////
  // decoded configuration and access terms

  logic       active;
  logic       big;
  logic       halve;
  logic       hold_pol;
  logic       hold_drv;
  logic       sel;
  logic       rd_act;
  logic       wr_act;
  logic       tick;
  logic       is_local;
  logic       fwd;
  logic       insert;
  logic [1:0] be_host;

  assign active   = r.cfg_done &&
                    r.straps[STRAP_BUS_LSB +: 3] == BUS_TYPE_ALT &&
                    r.straps[STRAP_ALT];
  assign big      = ~r.straps[STRAP_ENDIAN];
  assign halve    = r.straps[STRAP_HALVE];
  assign hold_pol = r.straps[STRAP_HOLD_POL];
  assign hold_drv = r.straps[STRAP_HOLD_DRV];
  assign sel      = active & ~s_sel_n;
  assign rd_act   = ~s_iord_n | ~s_rd_n;
  assign wr_act   = ~s_iowr_n | ~s_we0_n;
  // the sequencer leaves idle and done only on every other edge when halving
  assign tick     = ~halve | r.phase;
  assign be_host  = {~s_csh_n, ~s_csl_n};
  assign is_local = (r.addr[ADDR_W-1:1] == REG_ID_ADDR[ADDR_W-1:1]) &&
                    ~r.addr[MEM_SPACE_BIT];
  // while locked only the id and misc registers answer
  assign fwd      = ~is_local & ~r.misc[MISC_LOCK_BIT];
  assign insert   = sel && r.st != PCC_DEV_DONE;

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_r = r;
    // pins are metastable-prone, nothing reads s1 but s2
    next_r.s1 = {config_straps_i, bus.upper_addr_latch_in, bus.card_space_select_n,
                 bus.io_read_strobe_n, bus.io_write_strobe_n,
                 bus.general_read_strobe_n, bus.low_write_strobe_n,
                 bus.high_byte_select_n, bus.low_byte_select_n,
                 bus.muxed_addr_in, bus.host_data_bus};
    next_r.s2 = r.s1;

    // straps are taken once the synchroniser has filled after release
    if (!r.cfg_done)
    begin
      if (r.settle == STRAP_SETTLE)
      begin
        next_r.straps   = s_straps;
        next_r.cfg_done = 1'b1;
      end
      else
      begin
        next_r.settle = r.settle + 2'h1;
      end
    end

    next_r.phase    = halve ? ~r.phase : 1'b1;
    next_r.ale_prev = s_ale;
    if (active && r.ale_prev && !s_ale)
    begin
      next_r.upper = s_addr[UP_W-1:0];
    end

    unique case (r.st)
      PCC_DEV_IDLE:
      begin
        if (tick && sel && (rd_act || wr_act))
        begin
          next_r.addr  = {r.upper, s_addr};
          next_r.we    = wr_act & ~rd_act;
          next_r.be    = big ? {be_host[0], be_host[1]} : be_host;
          next_r.wdata = pcc_swap(s_data, big);
          next_r.st    = PCC_DEV_BUSY;
        end
      end
      PCC_DEV_BUSY:
      begin
        if (!fwd)
        begin
          if (is_local && r.we && r.be[1])
          begin
            next_r.misc = r.wdata[15:8];
          end
          // blocked reads return zero, blocked writes are dropped
          next_r.rdata = is_local ? pcc_swap({r.misc, ID_VALUE}, big) : '0;
          next_r.st    = PCC_DEV_DONE;
        end
        else if (req_ack_i)
        begin
          next_r.rdata = pcc_swap(req_rdata_i, big);
          next_r.st    = PCC_DEV_DONE;
        end
      end
      PCC_DEV_DONE:
      begin
        if (tick && !(rd_act || wr_act))
        begin
          next_r.st = PCC_DEV_IDLE;
        end
      end
      default:
      begin
        next_r.st = PCC_DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      r <= RESET_STATE;
    end
    else
    begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  assign bus.hold_out     = insert ^ ~hold_pol;
  assign bus.hold_oe      = active & (hold_drv | sel);
  assign bus.dev_data_out = r.rdata;
  assign bus.dev_data_oe  = sel && rd_act && !r.we && r.st == PCC_DEV_DONE;

  assign req_o         = (r.st == PCC_DEV_BUSY) & fwd;
  assign req_we_o      = r.we;
  assign req_addr_o    = r.addr;
  assign req_be_o      = r.be;
  assign req_wdata_o   = r.wdata;
  assign cfg_valid_o   = r.cfg_done;
  assign mode_active_o = active;
  assign big_endian_o  = r.cfg_done & big;
  assign regmem_lock_o = r.misc[MISC_LOCK_BIT];

endmodule // pcc_dev
`default_nettype wire

// file: pcc_host.sv
/*
  Processor end of the card-slot host port: runs one access per
  command through latch, setup and strobe phases and waits on hold.
  Assumes the controller end sits on the same interface instance and
  that hold_active_high_i matches the controller's polarity strap.
*/
`timescale 1ns/100ps
`default_nettype none
module pcc_host
  import pcc_pkg::*;
#(
  parameter int   PHASE_CYC   = HOST_PHASE_CYC,
  parameter logic USE_GENERAL = 1'b0
)(
  input  wire logic              clk_i,
  input  wire logic              arst_n_i,
  pcc_if.host                    bus,
  input  wire logic              hold_active_high_i,
  input  wire logic              cmd_valid_i,
  input  wire logic              cmd_we_i,
  input  wire logic [ADDR_W-1:0] cmd_addr_i,
  input  wire logic [1:0]        cmd_be_i,
  input  wire logic [DATA_W-1:0] cmd_wdata_i,
  output logic                   cmd_ready_o,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o
);

  typedef struct packed {
    pcc_host_st_t      st;
    logic [7:0]        cnt;
    logic [DATA_W:0]   s1;
    logic [DATA_W:0]   s2;
    logic [ADDR_W-1:0] addr;
    logic              we;
    logic [1:0]        be;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic              rsp;
  } pcc_host_state_t;

  pcc_host_state_t r;
  pcc_host_state_t next_r;

  logic       last;
  logic       wait_seen;
  logic       in_cyc;
  logic       strobe;
  logic [7:0] phase_max;

  assign phase_max = 8'(PHASE_CYC - 1);
  assign last      = r.cnt >= phase_max;
  assign wait_seen = hold_active_high_i ? r.s2[DATA_W] : ~r.s2[DATA_W];
  assign in_cyc    = r.st inside {PCC_H_SETUP, PCC_H_STROBE, PCC_H_END};
  assign strobe    = r.st == PCC_H_STROBE;

  always_comb
  begin
    next_r     = r;
    next_r.s1  = {bus.hold_level, bus.host_data_bus};
    next_r.s2  = r.s1;
    next_r.rsp = 1'b0;
    next_r.cnt = last ? 8'h00 : r.cnt + 8'h01;
    unique case (r.st)
      PCC_H_IDLE:
      begin
        next_r.cnt = 8'h00;
        if (cmd_valid_i)
        begin
          next_r.addr  = cmd_addr_i;
          next_r.we    = cmd_we_i;
          next_r.be    = cmd_be_i;
          next_r.wdata = cmd_wdata_i;
          next_r.st    = PCC_H_ALE;
        end
      end
      PCC_H_ALE:    if (last) next_r.st = PCC_H_LATCH;
      PCC_H_LATCH:  if (last) next_r.st = PCC_H_SETUP;
      PCC_H_SETUP:  if (last) next_r.st = PCC_H_STROBE;
      PCC_H_STROBE:
      begin
        // hold is trusted only after the controller had time to see the strobe
        if (!last)
        begin
          next_r.cnt = r.cnt + 8'h01;
        end
        else if (!wait_seen)
        begin
          next_r.rdata = r.s2[DATA_W-1:0];
          next_r.cnt   = 8'h00;
          next_r.st    = PCC_H_END;
        end
        else
        begin
          next_r.cnt = r.cnt;
        end
      end
      PCC_H_END:
      begin
        if (last)
        begin
          next_r.rsp = 1'b1;
          next_r.st  = PCC_H_IDLE;
        end
      end
      default: next_r.st = PCC_H_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      r <= '{st: PCC_H_IDLE, default: '0};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign bus.upper_addr_latch_in = r.st == PCC_H_ALE;
  // upper bits stay on the bus through the falling latch edge
  assign bus.muxed_addr_in       = (r.st == PCC_H_ALE || r.st == PCC_H_LATCH) ?
                                   {2'h0, r.addr[ADDR_W-1:LOW_W]} :
                                   r.addr[LOW_W-1:0];
  assign bus.card_space_select_n   = ~in_cyc;
  assign bus.high_byte_select_n    = ~(in_cyc & r.be[1]);
  assign bus.low_byte_select_n     = ~(in_cyc & r.be[0]);
  assign bus.io_read_strobe_n      = ~(strobe & ~r.we & ~USE_GENERAL);
  assign bus.io_write_strobe_n     = ~(strobe & r.we & ~USE_GENERAL);
  assign bus.general_read_strobe_n = ~(strobe & ~r.we & USE_GENERAL);
  assign bus.low_write_strobe_n    = ~(strobe & r.we & USE_GENERAL);
  assign bus.unused_addr_inputs    = 4'hf;
  assign bus.mem_reg_select_n      = 1'b1;
  assign bus.chip_select_n         = 1'b1;
  assign bus.bus_start_n           = 1'b1;
  assign bus.host_data_out         = r.wdata;
  assign bus.host_data_oe          = r.we & (r.st == PCC_H_SETUP || strobe);

  assign cmd_ready_o = r.st == PCC_H_IDLE;
  assign rsp_valid_o = r.rsp;
  assign rsp_rdata_o = r.rdata;

endmodule // pcc_host
`default_nettype wire

// file: pcc_chk_sva.sv
/*
  Pin level checker for the card-slot host port, placed beside the
  interface that joins the processor end and the controller end.
  Assumes straps stay still for a few clocks after reset release.
*/
`timescale 1ns/100ps
`default_nettype none
module pcc_chk
  import pcc_pkg::*;
(
  input wire logic               clk_i,
  input wire logic               arst_n_i,
  input wire logic [STRAP_W-1:0] config_straps_i,
  input wire logic               upper_addr_latch_in,
  input wire logic               card_space_select_n,
  input wire logic               io_read_strobe_n,
  input wire logic               io_write_strobe_n,
  input wire logic               general_read_strobe_n,
  input wire logic               low_write_strobe_n,
  input wire logic               mem_reg_select_n,
  input wire logic               chip_select_n,
  input wire logic               bus_start_n,
  input wire logic [3:0]         unused_addr_inputs,
  input wire logic [12:0]        muxed_addr_in,
  input wire logic               dev_data_oe,
  input wire logic               hold_out,
  input wire logic               hold_oe
);
  logic [3:0]         cnt;
  logic [STRAP_W-1:0] cap;
  logic               act;
  logic               ins;

  ////////////////////////////////////////////////////////////////////
  // own copy of the straps, so the bench may scramble the pins later
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cnt <= 4'h0;
      cap <= '0;
    end
    else
    begin
      if (cnt != 4'hf) cnt <= cnt + 4'h1;
      if (cnt == 4'h1) cap <= config_straps_i;
    end
  end
  assign act = (cnt > 4'h7) && (cap[3:1] == BUS_TYPE_ALT) && cap[STRAP_ALT];
  assign ins = cap[STRAP_HOLD_POL];

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_tied_high: assert property (unused_addr_inputs == 4'hf && mem_reg_select_n
    && chip_select_n && bus_start_n) else $error("unused inputs not high");
  a_strobe_select: assert property ((!io_read_strobe_n || !io_write_strobe_n)
    |-> !card_space_select_n) else $error("strobe without card select");
  a_one_strobe: assert property (io_read_strobe_n || io_write_strobe_n)
    else $error("read and write strobes together");
  a_latch_stable: assert property ($fell(upper_addr_latch_in) |-> $stable(muxed_addr_in))
    else $error("upper address moved at latch fall");
  a_no_write_drive: assert property (dev_data_oe |-> io_write_strobe_n && low_write_strobe_n)
    else $error("device drives data during write");
  a_read_drive: assert property ($rose(dev_data_oe)
    |-> !io_read_strobe_n || !general_read_strobe_n) else $error("data driven without read");
  a_off_silent: assert property ((cnt > 4'h7 && !act) |-> !dev_data_oe && !hold_oe)
    else $error("device drives pins outside its mode");
  a_sel_waits: assert property ((act && $fell(card_space_select_n))
    |-> ##5 (hold_oe && hold_out == ins)) else $error("no wait after select");
  a_strobe_waits: assert property ((act && ($fell(io_read_strobe_n)
    || $fell(io_write_strobe_n))) |-> hold_oe && hold_out == ins) else $error("no wait at strobe");
  a_data_ready: assert property ((act && $rose(io_read_strobe_n)) |-> $past(dev_data_oe))
    else $error("read ended before data was driven");
  a_hold_driven: assert property ((act && cap[STRAP_HOLD_DRV]) |-> hold_oe)
    else $error("hold not driven");
  a_hold_floats: assert property ((card_space_select_n[*4] ##0 (act && !cap[STRAP_HOLD_DRV]))
    |-> !hold_oe) else $error("hold driven while deselected");
endmodule // pcc_chk
`default_nettype wire

// file: tb_top.sv
/*
  Self-checking bench: both ends of the card-slot port on one
  interface, a small arbiter model with random latency behind the
  controller end. Assumes one shared 10 MHz host bus clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import pcc_pkg::*;
;
  logic               clk_i = 1'b0;
  logic               arst_n_i, hold_active_high_i;
  logic [STRAP_W-1:0] config_straps_i;
  logic               cmd_valid_i, cmd_we_i, cmd_ready_o, rsp_valid_o;
  logic [ADDR_W-1:0]  cmd_addr_i, req_addr_o, last_addr;
  logic [1:0]         cmd_be_i, req_be_o, last_be;
  logic [DATA_W-1:0]  cmd_wdata_i, rsp_rdata_o, req_wdata_o, req_rdata_i, last_wd, got;
  logic               req_o, req_we_o, req_ack_i, last_we;
  logic               cfg_valid_o, mode_active_o, big_endian_o, regmem_lock_o;
  logic [15:0]        nreq, n0;
  logic [15:0]        mem [0:255];
  logic [15:0]        sh [0:255];
  integer             seed, fails, checks, dly;

  pcc_if u_pcc_if ();
  pcc_dev u_pcc_dev (.clk_i, .arst_n_i, .bus(u_pcc_if.dev), .config_straps_i, .req_o,
    .req_we_o, .req_addr_o, .req_be_o, .req_wdata_o, .req_ack_i, .req_rdata_i,
    .cfg_valid_o, .mode_active_o, .big_endian_o, .regmem_lock_o);
  pcc_host u_pcc_host (.clk_i, .arst_n_i, .bus(u_pcc_if.host), .hold_active_high_i,
    .cmd_valid_i, .cmd_we_i, .cmd_addr_i, .cmd_be_i, .cmd_wdata_i, .cmd_ready_o,
    .rsp_valid_o, .rsp_rdata_o);
  pcc_chk u_pcc_chk (.clk_i, .arst_n_i, .config_straps_i,
    .upper_addr_latch_in(u_pcc_if.upper_addr_latch_in),
    .card_space_select_n(u_pcc_if.card_space_select_n),
    .io_read_strobe_n(u_pcc_if.io_read_strobe_n), .io_write_strobe_n(u_pcc_if.io_write_strobe_n),
    .general_read_strobe_n(u_pcc_if.general_read_strobe_n),
    .low_write_strobe_n(u_pcc_if.low_write_strobe_n),
    .mem_reg_select_n(u_pcc_if.mem_reg_select_n), .chip_select_n(u_pcc_if.chip_select_n),
    .bus_start_n(u_pcc_if.bus_start_n), .unused_addr_inputs(u_pcc_if.unused_addr_inputs),
    .muxed_addr_in(u_pcc_if.muxed_addr_in), .dev_data_oe(u_pcc_if.dev_data_oe),
    .hold_out(u_pcc_if.hold_out), .hold_oe(u_pcc_if.hold_oe));

  always #50 clk_i = ~clk_i;

  //////////////////////////////////////////////////////////////////////
  // arbiter model: random latency, ack held until the request drops
  always @(negedge clk_i)
  begin
    // the model is the only writer of its memory, so it clears itself in reset
    if (!arst_n_i)
    begin
      req_ack_i <= 1'b0;
      dly       <= 0;
      nreq      <= 16'h0;
      for (int i = 0; i < 256; i++) mem[i] <= 16'h0;
    end
    else if (req_o !== 1'b1)
    begin
      req_ack_i <= 1'b0;
      dly       <= $random(seed) & 3;
    end
    else if (!req_ack_i)
    begin
      if (dly != 0) dly <= dly - 1;
      else
      begin
        req_ack_i   <= 1'b1;
        req_rdata_i <= mem[req_addr_o[8:1]];
        if (req_we_o) mem[req_addr_o[8:1]] <= merge(mem[req_addr_o[8:1]], req_wdata_o, req_be_o);
        {last_addr, last_we, last_be, last_wd} <= {req_addr_o, req_we_o, req_be_o, req_wdata_o};
        nreq <= nreq + 16'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] merge(input logic [15:0] o, n, input logic [1:0] be);
    return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
  endfunction
  function automatic logic [15:0] swap(input logic [15:0] x);
    return {x[7:0], x[15:8]};
  endfunction

  task automatic chk(input logic [23:0] g, e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic do_reset(input logic [15:0] s);
    arst_n_i           = 1'b0;
    config_straps_i    = s;
    hold_active_high_i = s[STRAP_HOLD_POL];
    for (int i = 0; i < 256; i++) sh[i] = 16'h0;
    repeat (6) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (10) @(negedge clk_i);
    // scrambled pins must not reach the captured configuration
    config_straps_i = 16'($random(seed));
    chk(cfg_valid_o, 1'b1);
    chk(mode_active_o, s[3:1] == 3'h7 && s[11]);
    chk(big_endian_o, !s[4]);
    chk(regmem_lock_o, 1'b1);
  endtask

  task automatic xfer(input logic we, input logic [23:0] a, input logic [1:0] be,
                      input logic [15:0] wd, output logic [15:0] rd);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
    {cmd_valid_i, cmd_we_i, cmd_addr_i, cmd_be_i, cmd_wdata_i} = {1'b1, we, a, be, wd};
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1 && n < 2000)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 2000)
    begin
      fails++;
      wrap_up;
    end
    else
    begin
      rd = rsp_rdata_o;
      @(negedge clk_i);
    end
  endtask

  // forwarded writes, first to 24'hfffffe and 24'h800000 then random, each read back through the arbiter
  task automatic mem_run(input int cnt, input logic big);
    logic [31:0] r, w;
    logic [23:0] a;
    logic [1:0]  be, ib;
    logic [15:0] m;
    for (int k = 0; k < cnt; k++)
    begin
      r  = $random(seed);
      w  = $random(seed);
      a  = (k == 0) ? 24'hfffffe : (k == 1) ? 24'h800000 : {1'b1, r[22:1], 1'b0};
      be = (k < 2 || r[24:23] == 2'h0) ? 2'h3 : r[24:23];
      ib = big ? {be[0], be[1]} : be;
      m  = {{8{ib[1]}}, {8{ib[0]}}};
      xfer(1'b1, a, be, w[15:0], got);
      chk(last_addr, a);
      chk(last_we, 1'b1);
      chk(last_be, ib);
      chk(last_wd & m, (big ? swap(w[15:0]) : w[15:0]) & m);
      sh[a[8:1]] = merge(sh[a[8:1]], w[15:0], be);
      xfer(1'b0, a, 2'h3, 16'h0, got);
      chk(last_we, 1'b0);
      chk(got, sh[a[8:1]]);
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    {seed, fails, checks} = {32'h0f11, 64'h0};
    {arst_n_i, hold_active_high_i, config_straps_i} = '0;
    {cmd_valid_i, cmd_we_i, cmd_addr_i, cmd_be_i, cmd_wdata_i} = '0;
    // little endian, wait high, hold always driven, undivided clock
    do_reset(16'h883e);
    xfer(1'b0, REG_ID_ADDR, 2'h3, 16'h0, got);
    chk(got, {MISC_RESET, ID_DEFAULT});
    xfer(1'b1, 24'h800010, 2'h3, 16'h1234, got);
    xfer(1'b0, 24'h800010, 2'h3, 16'h0, got);
    chk(got, 16'h0);
    chk(nreq, 16'h0);
    xfer(1'b1, REG_ID_ADDR, 2'h2, 16'h0, got);
    chk(regmem_lock_o, 1'b0);
    xfer(1'b0, REG_MISC_ADDR, 2'h3, 16'h0, got);
    chk(got, {8'h00, ID_DEFAULT});
    mem_run(8, 1'b0);
    // big endian, wait low, hold floated, halved clock
    do_reset(16'h180e);
    xfer(1'b1, REG_ID_ADDR, 2'h3, 16'h0, got);
    chk(regmem_lock_o, 1'b0);
    mem_run(8, 1'b1);
    // primary family selected: the port stays off the bus
    do_reset(16'h000e);
    n0 = nreq;
    xfer(1'b0, 24'h800010, 2'h3, 16'h0, got);
    chk(got, 16'hffff);
    chk(nreq, n0);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
